/* logic/op_exec.sv */
// Decode and execute of the clear, invert, decrement and watchdog
// restart instructions for an 8-bit core.
// Assumes the fetch unit holds insn stable for a whole instruction
// cycle and that the register file answers file_rd_data combinationally
// for file_addr on the same clock.
`timescale 1ns/1ps
// Function
// - Zero accumulator, set zero flag, one cycle.
// - Invert register; destination bit picks target.
// - Watchdog restart clears watchdog counter, one cycle.
// - Watchdog restart clears prescaler same cycle.
// - Watchdog restart sets expiry and sleep flags.
// - Decrement register; destination bit picks target.
// - Seven-bit operand addresses registers 0x00-0x7F.
// - One instruction cycle equals four oscillator clocks.
module op_exec
    import op_exec_pkg::*;
#(
    parameter int DW = DATA_W
)(
    input wire logic clock,
    input wire logic reset,
    input wire logic [INSN_W-1:0] insn,
    input wire logic insn_valid,
    input wire logic [DW-1:0] file_rd_data,
    output logic [ADDR_W-1:0] file_addr,
    output logic [DW-1:0] file_wr_data,
    output logic file_wr_en,
    output logic [DW-1:0] acc_value,
    output logic result_null_flag,
    output logic expiry_flag,
    output logic sleep_status_flag,
    output logic watchdog_restart,
    output logic prescaler_restart,
    output logic insn_done
);
    // Quarter-cycle phase, accumulator, flags and write-back registers.
    logic [1:0] phase_ff, nxt_phase;
    logic [DW-1:0] acc_ff, nxt_acc;
    logic zero_ff, nxt_zero;
    logic expiry_ff, nxt_expiry;
    logic sleep_ff, nxt_sleep;
    logic wd_ff, nxt_wd;
    logic pre_ff, nxt_pre;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DW-1:0] wdata_ff, nxt_wdata;
    logic wen_ff, nxt_wen;
    logic done_ff, nxt_done;
    logic [DW-1:0] result;
    logic is_inv, is_dec, exec_now;

    // True when an 8-bit value is zero, used for both byte operations.
    function automatic logic is_null(input logic [DW-1:0] v);
        return v == DW'(DATA_ZERO);
    endfunction

    // Operand address comes straight from the low seven bits.
    assign file_addr = insn[ADDR_W-1:0];

    // The phase counter wraps on its own; a two-bit count rolls over
    // after four clocks, which is exactly one instruction cycle.
    always_comb
    begin
        nxt_phase = phase_ff + 2'h1;
    end

    // Decode; execution lands on the last of four phases so each
    // instruction occupies exactly one instruction cycle.
    always_comb
    begin
        is_inv = insn[OPC_HI:OPC_LO] == OP_INVERT;
        is_dec = insn[OPC_HI:OPC_LO] == OP_MINUS_ONE;
        exec_now = insn_valid && (phase_ff == PHASE_LAST);
        // Other opcodes leave result at zero; it is then never used.
        result = DW'(DATA_ZERO);
        if (is_inv)
        begin
            result = ~file_rd_data;
        end
        else if (is_dec)
        begin
            result = file_rd_data - DW'(DATA_ONE);
        end
    end

    // Next state of accumulator, flags, pulses and write-back. Accumulator,
    // flags, address and data hold by default and the pulses default low, so
    // refused opcodes change nothing but the done pulse.
    always_comb
    begin
        nxt_acc = acc_ff;
        nxt_zero = zero_ff;
        nxt_expiry = expiry_ff;
        nxt_sleep = sleep_ff;
        nxt_wd = 1'b0;
        nxt_pre = 1'b0;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_wen = 1'b0;
        nxt_done = exec_now;
        if (exec_now)
        begin
            if (insn == OP_ACC_ZERO)
            begin
                nxt_acc = DW'(DATA_ZERO);
                nxt_zero = 1'b1;
            end
            // Watchdog restart touches only the two status flags and the two pulses,
            // so the zero flag keeps whatever the last clear, invert or decrement left.
            else if (insn == OP_WD_RESTART)
            begin
                nxt_wd = 1'b1;
                nxt_pre = 1'b1;
                nxt_expiry = 1'b1;
                nxt_sleep = 1'b1;
            end
            else if (is_inv || is_dec)
            begin
                nxt_zero = is_null(result);
                // Destination bit set sends the result back to the file;
                // clear keeps it in the accumulator and the file untouched.
                if (insn[DEST_BIT])
                begin
                    nxt_addr = insn[ADDR_W-1:0];
                    nxt_wdata = result;
                    nxt_wen = 1'b1;
                end
                else
                begin
                    nxt_acc = result;
                end
            end
        end
    end

    // Phase register. It runs free from reset release, so execute slots
    // fall every fourth clock whether or not a word is waiting.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            phase_ff <= 2'h0;
        end
        else
        begin
            phase_ff <= nxt_phase;
        end
    end

    // Accumulator and zero flag. The accumulator clears on reset so the
    // first byte operation never sees an unknown value.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            acc_ff <= DW'(DATA_ZERO);
            zero_ff <= 1'b0;
        end
        else
        begin
            acc_ff <= nxt_acc;
            zero_ff <= nxt_zero;
        end
    end

    // Status flags and watchdog pulses. The flags come up set, the same
    // value a watchdog restart leaves, so software sees a clean start.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            expiry_ff <= 1'b1;
            sleep_ff <= 1'b1;
            wd_ff <= 1'b0;
            pre_ff <= 1'b0;
        end
        else
        begin
            expiry_ff <= nxt_expiry;
            sleep_ff <= nxt_sleep;
            wd_ff <= nxt_wd;
            pre_ff <= nxt_pre;
        end
    end

    // Write-back and done pulse. Registering these costs one clock but
    // keeps the file write off the combinational read path.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            addr_ff <= ADDR_ZERO;
            wdata_ff <= DW'(DATA_ZERO);
            wen_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            wen_ff <= nxt_wen;
            done_ff <= nxt_done;
        end
    end

    // Only data and strobe leave registered; the write address is file_addr,
    // which the file holds a clock, so the write lands one clock after execute.
    assign file_wr_data = wdata_ff;
    assign file_wr_en = wen_ff;

    // Accumulator and zero flag stand until the next instruction that
    // writes them.
    assign acc_value = acc_ff;
    assign result_null_flag = zero_ff;

    // Status flags and the one-clock watchdog and prescaler pulses.
    assign expiry_flag = expiry_ff;
    assign sleep_status_flag = sleep_ff;
    assign watchdog_restart = wd_ff;
    assign prescaler_restart = pre_ff;
    assign insn_done = done_ff;
endmodule // op_exec

/* logic/op_exec_pkg.sv */
// Constants shared by the four-instruction execute block.
// Assumes a 14-bit instruction word and an 8-bit data path.
package op_exec_pkg;
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PHASES_PER_CYCLE = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [13:0] OP_ACC_ZERO = 14'h0103;
    localparam logic [13:0] OP_WD_RESTART = 14'h0064;
    localparam logic [5:0] OP_INVERT = 6'h09;
    localparam logic [5:0] OP_MINUS_ONE = 6'h03;
    localparam int OPC_HI = 13;
    localparam int OPC_LO = 8;
    localparam int DEST_BIT = 7;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [7:0] DATA_ONE = 8'h01;
    localparam logic [6:0] ADDR_ZERO = 7'h00;
endpackage

/* verif/file_model.sv */
// Register file stand-in: combinational read, late write.
`timescale 1ns/1ps
module file_model (
    input logic clock, file_wr_en,
    input logic [6:0] file_addr,
    input logic [7:0] file_wr_data,
    output logic [7:0] file_rd_data
);
    logic [7:0] mem_ff [128];
    logic [6:0] addr_ff;
    // Each cell starts at its own address, so results are traceable.
    initial for (int i = 0; i < 128; i++) mem_ff[i] = 8'(i);
    assign file_rd_data = mem_ff[file_addr];
    // The write lands a clock after execute, so the address is kept.
    always @(posedge clock)
    begin
        addr_ff <= file_addr;
        if (file_wr_en) mem_ff[addr_ff] <= file_wr_data;
    end
endmodule // file_model

/* verif/op_exec_sva.sv */
// Checker on the op_exec ports.
// Assumes the bind below and a 4-clock instruction cycle.
`timescale 1ns/1ps
module op_exec_sva (
    input logic clock, reset, insn_done, file_wr_en, result_null_flag,
    input logic expiry_flag, sleep_status_flag, watchdog_restart,
    input logic prescaler_restart,
    input logic [13:0] insn,
    input logic [7:0] file_rd_data, file_wr_data, acc_value,
    input logic [6:0] file_addr
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Results show in the cycle after the edge that executes.
    a_zero_acc: assert property (insn_done && $past(insn) == 14'h0103
        |-> acc_value == 8'h00 && result_null_flag) else $error("clear");
    a_invert_wr: assert property (insn_done && $past(insn[13:7]) == 7'h13
        |-> file_wr_en && file_wr_data == ~$past(file_rd_data)) else $error("inv");
    a_invert_acc: assert property (insn_done && $past(insn[13:7]) == 7'h12
        |-> !file_wr_en && acc_value == ~$past(file_rd_data)) else $error("inv");
    a_dec_wr: assert property (insn_done && $past(insn[13:7]) == 7'h07
        |-> file_wr_data == $past(file_rd_data) - 8'h01) else $error("dec");
    a_wd_pulse: assert property (insn_done && $past(insn) == 14'h0064
        |-> watchdog_restart && prescaler_restart) else $error("wd");
    a_wd_flags: assert property (watchdog_restart |-> expiry_flag
        && sleep_status_flag && $stable(result_null_flag)) else $error("flags");
    a_addr_pass: assert property (file_addr == insn[6:0]) else $error("addr");
    a_cycle_gap: assert property (insn_done |=> !insn_done [*3]) else $error("gap");
endmodule // op_exec_sva
bind op_exec op_exec_sva op_exec_sva_inst (.*);

/* verif/op_exec_tb.sv */
// Bench for op_exec: a table of instructions with expected results.
// Assumes the four-clock cycle starts at reset release.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
module op_exec_tb;
    logic clock = 0, reset = 1, insn_valid = 0, file_wr_en, insn_done;
    logic result_null_flag, expiry_flag, sleep_status_flag;
    logic watchdog_restart, prescaler_restart;
    logic [13:0] insn = 14'h0000;
    logic [7:0] file_rd_data, file_wr_data, acc_value;
    logic [6:0] file_addr;
    int num_errors = 0, checked = 0, cycles = 0;
    logic [13:0] ops [7] = '{14'h0381, 14'h0301, 14'h09FF, 14'h097F,
        14'h0103, 14'h0103, 14'h0064};
    logic [7:0] acc_x [7] = '{8'h00, 8'hFF, 8'hFF, ~8'h80, 8'h7F, 8'h00,
        8'h00};
    logic zero_x [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    // Write strobe and data seen after each word; data hold between.
    logic [8:0] wr_x [7] = '{9'h100, 9'h000, 9'h180, 9'h080, 9'h080,
        9'h080, 9'h080};
    op_exec op_exec_inst (.*);
    file_model file_model_inst (.*);
    initial forever #50 clock = ~clock;
    task automatic give_verdict();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Present one word for a whole cycle, then look between edges.
    task automatic run(input logic [13:0] op, input logic v);
        repeat (4) @(posedge clock);
        insn <= op;
        insn_valid <= v;
        repeat (4) @(posedge clock);
        insn_valid <= 1'b0;
        @(negedge clock);
    endtask
    // Cuts a hang short; the run needs under a hundred cycles.
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 400) begin num_errors++; give_verdict(); end
    end
    initial
    begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            run(ops[i], i != 4);
            `CHK(acc_value, acc_x[i])
            `CHK(result_null_flag, zero_x[i])
            `CHK(insn_done, i != 4)
            `CHK({file_wr_en, file_wr_data}, wr_x[i])
            `CHK(watchdog_restart, i == 6)
            `CHK(prescaler_restart, i == 6)
        end
        `CHK({watchdog_restart, prescaler_restart}, 2'h3)
        `CHK({expiry_flag, sleep_status_flag}, 2'h3)
        give_verdict();
    end
endmodule // op_exec_tb
